//--- rtl/drive_status_comparators.v
// Status comparators of a motor drive: arrival, overload, PID deviation
// Assumes all inputs synchronous to ref_clk; outputs drive open-collector
// terminals, so every flag is active low.
// Margins and the default deviation level truncate by integer division;
// max_freq times 20 and PID_FULL_SCALE times 30 must fit in 32 bits.
`timescale 1ns/10ps
`include "drive_status_defines.vh"

module drive_status_comparators #(
    parameter FW = 16,
    parameter IW = 16,
    parameter PW = 16,
    parameter [PW-1:0] PID_FULL_SCALE = 16'h2710
) (
    // Clock and reset
    input  wire          ref_clk,
    input  wire          reset_n,
    // Frequency inputs
    input  wire [FW-1:0] out_freq,
    input  wire [FW-1:0] max_freq,
    input  wire [FW-1:0] set_frequency,
    // Frequency thresholds
    input  wire [FW-1:0] accel_threshold_a,
    input  wire [FW-1:0] accel_threshold_b,
    input  wire [FW-1:0] decel_threshold_a,
    input  wire [FW-1:0] decel_threshold_b,
    // Current inputs
    input  wire [IW-1:0] out_current,
    input  wire [IW-1:0] overload_level_one,
    input  wire [IW-1:0] overload_level_two,
    // PID inputs
    input  wire [PW-1:0] pid_setpoint,
    input  wire [PW-1:0] pid_process,
    input  wire          deviation_load,
    input  wire [PW-1:0] deviation_level,
    // Active-low flag outputs
    output reg           arrival_at_setpoint_n,
    output reg           arrival_level_a_n,
    output reg           arrival_pulse_a_n,
    output reg           arrival_level_b_n,
    output reg           arrival_pulse_b_n,
    output reg           overload_notice_one_n,
    output reg           overload_notice_two_n,
    output reg           pid_deviation_flag_n,
    // Active deviation level
    output reg  [PW-1:0] deviation_level_ff
);

    reg  [FW-1:0] prev_freq_ff;
    reg  [FW-1:0] on_margin_ff;
    reg  [FW-1:0] off_margin_ff;
    reg           setp_ff;
    reg           lvl_a_ff;
    reg           lvl_b_ff;
    reg           nxt_setp;
    reg           nxt_lvl_a;
    reg           nxt_lvl_b;
    reg  [FW:0]   sp_lo;
    reg  [FW:0]   sp_hi;
    reg  [PW-1:0] pid_err;
    reg           accelerating;
    reg           decelerating;
    reg  [FW-1:0] nxt_on_margin;
    reg  [FW-1:0] nxt_off_margin;
    reg           nxt_ovl_one;
    reg           nxt_ovl_two;
    reg           nxt_dev_flag;
    reg  [PW-1:0] nxt_dev_level;
    wire          pulse_a;
    wire          pulse_b;
    wire [31:0]   on_full;
    wire [31:0]   off_full;
    wire [31:0]   dev_full;
    wire [31:0]   on_div;
    wire [31:0]   off_div;
    wire [31:0]   dev_div;
    wire [PW-1:0] dev_rst;

    // ----------------------------------------------------------------
    // Direction from previous frequency sample
    // ----------------------------------------------------------------
    always @* begin
        // Steady frequency is neither, pulse flags then hold
        accelerating = 1'b0;
        decelerating = 1'b0;
        if (out_freq > prev_freq_ff) begin
            accelerating = 1'b1;
        end else if (out_freq < prev_freq_ff) begin
            decelerating = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Margins from maximum frequency
    // ----------------------------------------------------------------
    assign on_full  = max_freq * `ON_MARGIN_PERMILLE;
    assign off_full = max_freq * `OFF_MARGIN_PERMILLE;
    assign on_div   = on_full / `PERMILLE_FULL;
    assign off_div  = off_full / `PERMILLE_FULL;
    assign dev_full = PID_FULL_SCALE * `DEV_LEVEL_RST_PERMILLE;
    assign dev_div  = dev_full / `PERMILLE_FULL;
    assign dev_rst  = dev_div[PW-1:0];

    // ----------------------------------------------------------------
    // Level arrival flags with hysteresis
    // ----------------------------------------------------------------
    always @* begin
        nxt_setp  = setp_ff;
        nxt_lvl_a = lvl_a_ff;
        nxt_lvl_b = lvl_b_ff;
        sp_lo = {1'b0, set_frequency} - {1'b0, on_margin_ff};
        sp_hi = {1'b0, set_frequency} + {1'b0, off_margin_ff};
        // Set frequency only; approach from below on early, off late
        if (sp_lo[FW] || {1'b0, out_freq} >= sp_lo) begin
            if ({1'b0, out_freq} <= {1'b0, set_frequency}
                + {1'b0, on_margin_ff}) begin
                nxt_setp = 1'b1;
            end
        end
        if (!sp_lo[FW] && {1'b0, out_freq} + {1'b0, off_margin_ff}
            < {1'b0, set_frequency}) begin
            nxt_setp = 1'b0;
        end else if ({1'b0, out_freq} > sp_hi) begin
            nxt_setp = 1'b0;
        end
        // Paired thresholds, margins shared by all arrival flags
        if ({1'b0, out_freq} + {1'b0, on_margin_ff}
            >= {1'b0, accel_threshold_a}) begin
            nxt_lvl_a = 1'b1;
        end else if ({1'b0, out_freq} + {1'b0, off_margin_ff}
                     < {1'b0, decel_threshold_a}) begin
            nxt_lvl_a = 1'b0;
        end
        if ({1'b0, out_freq} + {1'b0, on_margin_ff}
            >= {1'b0, accel_threshold_b}) begin
            nxt_lvl_b = 1'b1;
        end else if ({1'b0, out_freq} + {1'b0, off_margin_ff}
                     < {1'b0, decel_threshold_b}) begin
            nxt_lvl_b = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // PID error magnitude
    // ----------------------------------------------------------------
    always @* begin
        if (pid_setpoint >= pid_process) begin
            pid_err = pid_setpoint - pid_process;
        end else begin
            pid_err = pid_process - pid_setpoint;
        end
    end

    // ----------------------------------------------------------------
    // Pulse arrival flags
    // ----------------------------------------------------------------
    arrival_pulse #(
        .W (FW)
    ) u_pulse_a (
        .ref_clk      (ref_clk),
        .reset_n      (reset_n),
        .out_freq     (out_freq),
        .on_margin    (on_margin_ff),
        .off_margin   (off_margin_ff),
        .accelerating (accelerating),
        .decelerating (decelerating),
        .accel_thr    (accel_threshold_a),
        .decel_thr    (decel_threshold_a),
        .pulse_ff     (pulse_a)
    );

    arrival_pulse #(
        .W (FW)
    ) u_pulse_b (
        .ref_clk      (ref_clk),
        .reset_n      (reset_n),
        .out_freq     (out_freq),
        .on_margin    (on_margin_ff),
        .off_margin   (off_margin_ff),
        .accelerating (accelerating),
        .decelerating (decelerating),
        .accel_thr    (accel_threshold_b),
        .decel_thr    (decel_threshold_b),
        .pulse_ff     (pulse_b)
    );

    // ----------------------------------------------------------------
    // Margin values
    // ----------------------------------------------------------------
    always @* begin
        nxt_on_margin  = on_div[FW-1:0];
        nxt_off_margin = off_div[FW-1:0];
    end

    // ----------------------------------------------------------------
    // Direction and margin registers
    // ----------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            prev_freq_ff  <= {FW{1'b0}};
            on_margin_ff  <= {FW{1'b0}};
            off_margin_ff <= {FW{1'b0}};
        end else begin
            prev_freq_ff  <= out_freq;
            on_margin_ff  <= nxt_on_margin;
            off_margin_ff <= nxt_off_margin;
        end
    end

    // ----------------------------------------------------------------
    // Level arrival state
    // ----------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            setp_ff  <= 1'b0;
            lvl_a_ff <= 1'b0;
            lvl_b_ff <= 1'b0;
        end else begin
            setp_ff  <= nxt_setp;
            lvl_a_ff <= nxt_lvl_a;
            lvl_b_ff <= nxt_lvl_b;
        end
    end

    // ----------------------------------------------------------------
    // Overload notice, next state
    // ----------------------------------------------------------------
    always @* begin
        nxt_ovl_one = ~overload_notice_one_n;
        // Magnitude only, so regen braking counts as well
        if (out_current > overload_level_one) begin
            nxt_ovl_one = 1'b1;
        end else if (out_current < overload_level_one) begin
            nxt_ovl_one = 1'b0;
        end
    end

    always @* begin
        nxt_ovl_two = ~overload_notice_two_n;
        // Equal current holds the previous state
        if (out_current > overload_level_two) begin
            nxt_ovl_two = 1'b1;
        end else if (out_current < overload_level_two) begin
            nxt_ovl_two = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Deviation level and flag, next state
    // ----------------------------------------------------------------
    always @* begin
        nxt_dev_level = deviation_level_ff;
        nxt_dev_flag  = ~pid_deviation_flag_n;
        // Zero level falls back to the default
        if (deviation_load) begin
            nxt_dev_level = deviation_level;
        end else if (deviation_level_ff == {PW{1'b0}}) begin
            nxt_dev_level = dev_rst;
        end
        if (pid_err > deviation_level_ff) begin
            nxt_dev_flag = 1'b1;
        end else if (pid_err < deviation_level_ff) begin
            nxt_dev_flag = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Deviation level register
    // ----------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            deviation_level_ff <= {PW{1'b0}};
        end else begin
            deviation_level_ff <= nxt_dev_level;
        end
    end

    // ----------------------------------------------------------------
    // Arrival flag outputs
    // ----------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            arrival_at_setpoint_n <= `FLAG_OFF;
            arrival_level_a_n     <= `FLAG_OFF;
            arrival_pulse_a_n     <= `FLAG_OFF;
            arrival_level_b_n     <= `FLAG_OFF;
            arrival_pulse_b_n     <= `FLAG_OFF;
        end else begin
            arrival_at_setpoint_n <= ~setp_ff;
            arrival_level_a_n     <= ~lvl_a_ff;
            arrival_pulse_a_n     <= ~pulse_a;
            arrival_level_b_n     <= ~lvl_b_ff;
            arrival_pulse_b_n     <= ~pulse_b;
        end
    end

    // ----------------------------------------------------------------
    // Overload outputs
    // ----------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            overload_notice_one_n <= `FLAG_OFF;
            overload_notice_two_n <= `FLAG_OFF;
        end else begin
            overload_notice_one_n <= ~nxt_ovl_one;
            overload_notice_two_n <= ~nxt_ovl_two;
        end
    end

    // ----------------------------------------------------------------
    // Deviation output
    // ----------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            pid_deviation_flag_n <= `FLAG_OFF;
        end else begin
            pid_deviation_flag_n <= ~nxt_dev_flag;
        end
    end

endmodule

//--- rtl/drive_status_defines.vh
// Constants for the drive status comparator block
// Assumes values are unsigned fixed-point in a common unit per quantity
`ifndef DRIVE_STATUS_DEFINES_VH
`define DRIVE_STATUS_DEFINES_VH

// ----------------------------------------------------------------
// Hysteresis margins, per mille of maximum frequency
// ----------------------------------------------------------------
`define ON_MARGIN_PERMILLE   10
`define OFF_MARGIN_PERMILLE  20
`define PERMILLE_FULL        1000

// ----------------------------------------------------------------
// Deviation level default, loaded while the level is zero, per mille of full scale
// ----------------------------------------------------------------
`define DEV_LEVEL_RST_PERMILLE 30

// ----------------------------------------------------------------
// Flag output polarity
// ----------------------------------------------------------------
`define FLAG_ON   1'b0
`define FLAG_OFF  1'b1

`endif

//--- rtl/arrival_pulse.v
// Pulse-type frequency arrival detector around one threshold pair
// Assumes accel/decel direction flags from the enclosing block
`timescale 1ns/10ps

module arrival_pulse #(
    parameter W = 16
) (
    // Clock and reset
    input  wire         ref_clk,
    input  wire         reset_n,
    // Frequency and margins
    input  wire [W-1:0] out_freq,
    input  wire [W-1:0] on_margin,
    input  wire [W-1:0] off_margin,
    input  wire         accelerating,
    input  wire         decelerating,
    // Thresholds
    input  wire [W-1:0] accel_thr,
    input  wire [W-1:0] decel_thr,
    // Flag, active high internally
    output reg          pulse_ff
);

    reg nxt_pulse;
    reg [W:0] lo_a;
    reg [W:0] hi_a;
    reg [W:0] lo_d;
    reg [W:0] hi_d;

    // ----------------------------------------------------------------
    // On early by on margin, off late by off margin
    // ----------------------------------------------------------------
    always @* begin
        nxt_pulse = pulse_ff;
        lo_a = {1'b0, accel_thr} - {1'b0, on_margin};
        hi_a = {1'b0, accel_thr} + {1'b0, off_margin};
        lo_d = {1'b0, decel_thr} - {1'b0, off_margin};
        hi_d = {1'b0, decel_thr} + {1'b0, on_margin};
        if (accelerating) begin
            // Window on rising pass of accel threshold
            if (!pulse_ff && (lo_a[W] || {1'b0, out_freq} >= lo_a)
                && {1'b0, out_freq} <= hi_a) begin
                nxt_pulse = 1'b1;
            end else if ({1'b0, out_freq} > hi_a || (lo_a[W] == 1'b0
                         && {1'b0, out_freq} < lo_a)) begin
                nxt_pulse = 1'b0;
            end
        end else if (decelerating) begin
            if (!pulse_ff && {1'b0, out_freq} <= hi_d
                && (lo_d[W] || {1'b0, out_freq} >= lo_d)) begin
                nxt_pulse = 1'b1;
            end else if ((!lo_d[W] && {1'b0, out_freq} < lo_d)
                         || {1'b0, out_freq} > hi_d) begin
                nxt_pulse = 1'b0;
            end
        end
    end

    always @(posedge ref_clk) begin
        if (!reset_n) begin
            pulse_ff <= 1'b0;
        end else begin
            pulse_ff <= nxt_pulse;
        end
    end

endmodule

//--- bench/drive_status_sva.sv
// Port checker for the drive status comparators
// Assumes default 16-bit widths and PID_FULL_SCALE of 10000
`timescale 1ns/10ps
`include "drive_status_defines.vh"

module drive_status_sva (
    // Clock and reset
    input wire        ref_clk,
    input wire        reset_n,
    // Inputs
    input wire [15:0] out_freq,
    input wire [15:0] max_freq,
    input wire [15:0] set_frequency,
    input wire [15:0] accel_threshold_a,
    input wire [15:0] decel_threshold_a,
    input wire [15:0] out_current,
    input wire [15:0] overload_level_one,
    input wire [15:0] overload_level_two,
    input wire [15:0] pid_setpoint,
    input wire [15:0] pid_process,
    input wire        deviation_load,
    input wire [15:0] deviation_level,
    // Outputs
    input wire        arrival_at_setpoint_n,
    input wire        arrival_level_a_n,
    input wire        arrival_pulse_a_n,
    input wire        arrival_level_b_n,
    input wire        arrival_pulse_b_n,
    input wire        overload_notice_one_n,
    input wire        overload_notice_two_n,
    input wire        pid_deviation_flag_n,
    input wire [15:0] deviation_level_ff
);
    wire [31:0] on_m  = max_freq * `ON_MARGIN_PERMILLE / `PERMILLE_FULL;
    wire [31:0] off_m = max_freq * `OFF_MARGIN_PERMILLE / `PERMILLE_FULL;
    wire [15:0] err   = (pid_setpoint > pid_process) ?
                        pid_setpoint - pid_process : pid_process - pid_setpoint;
    wire [7:0]  flg_n = {pid_deviation_flag_n, overload_notice_two_n,
                         overload_notice_one_n, arrival_pulse_b_n,
                         arrival_level_b_n, arrival_pulse_a_n,
                         arrival_level_a_n, arrival_at_setpoint_n};

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    a_flags_reset: assert property (disable iff (1'b0)
        !reset_n |=> flg_n == 8'hFF && deviation_level_ff == 16'h0000)
        else $error("flags not cleared by reset");
    a_dev_default: assert property (reset_n && !$past(reset_n)
        && !deviation_load |=> deviation_level_ff == 16'h012C)
        else $error("deviation level default wrong");
    a_dev_load: assert property (deviation_load
        |=> deviation_level_ff == $past(deviation_level))
        else $error("deviation level not loaded");
    a_ovl_one_on: assert property (out_current > overload_level_one
        |=> !overload_notice_one_n) else $error("overload one not on");
    a_ovl_one_off: assert property (out_current < overload_level_one
        |=> overload_notice_one_n) else $error("overload one not off");
    a_ovl_two_on: assert property (out_current > overload_level_two
        |=> !overload_notice_two_n) else $error("overload two not on");
    a_dev_flag_on: assert property (err > deviation_level_ff
        |=> !pid_deviation_flag_n) else $error("deviation flag not on");
    a_dev_flag_off: assert property (err < deviation_level_ff
        |=> pid_deviation_flag_n) else $error("deviation flag not off");
    a_setpt_on: assert property (out_freq + on_m >= set_frequency
        && out_freq <= set_frequency + on_m |-> ##2 !arrival_at_setpoint_n)
        else $error("setpoint arrival not on");
    a_setpt_off: assert property (out_freq + off_m < set_frequency
        || out_freq > set_frequency + off_m |-> ##2 arrival_at_setpoint_n)
        else $error("setpoint arrival not off");
    a_lvl_a_on: assert property (out_freq + on_m >= accel_threshold_a
        |-> ##2 !arrival_level_a_n) else $error("level a not on");
    a_lvl_a_off: assert property (out_freq + off_m < decel_threshold_a
        && out_freq + on_m < accel_threshold_a |-> ##2 arrival_level_a_n)
        else $error("level a not off");
    a_pulse_a_on: assert property (out_freq > $past(out_freq)
        && out_freq + on_m >= accel_threshold_a
        && out_freq <= accel_threshold_a + off_m |-> ##2 !arrival_pulse_a_n)
        else $error("pulse a not on");

    cover property (!overload_notice_one_n);
    cover property (!arrival_pulse_a_n);
    cover property (deviation_load);
endmodule

bind drive_status_comparators drive_status_sva u_sva (.*);

//--- bench/relay_bank.sv
// Relays hung on the open-collector flag terminals
// Assumes a coil energises while its pin is pulled low
`timescale 1ns/10ps

module relay_bank (
    // Flag pins
    input  wire [7:0] pins_n,
    // Coil states
    output wire [7:0] coil_on
);
    assign coil_on = ~pins_n;
endmodule

//--- bench/tb_top.sv
// Self-checking bench for the drive status comparators
// Assumes default widths, max_freq 10000, flags settled in 2 cycles
`timescale 1ns/10ps
`define CHK(a,b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; \
    $display("Error %0t got %h exp %h", $time, a, b); end end

module tb_top;
    reg         ref_clk = 0, reset_n = 0, deviation_load = 0;
    reg  [15:0] out_freq = 0, max_freq = 16'h2710, set_frequency = 16'h1388;
    reg  [15:0] accel_threshold_a = 16'h0BB8, decel_threshold_a = 16'h07D0;
    reg  [15:0] accel_threshold_b = 16'h1770, decel_threshold_b = 16'h0000;
    reg  [15:0] out_current = 0, overload_level_one = 16'h03E8;
    reg  [15:0] overload_level_two = 16'h07D0, deviation_level = 0;
    reg  [15:0] pid_setpoint = 16'h03E8, pid_process = 16'h03E8;
    wire [7:0]  flags_n, coil_on;
    wire [15:0] deviation_level_ff;
    integer     miscompares = 0, cmp_count = 0, cyc = 0;

    drive_status_comparators u_dut (.*,
        .arrival_at_setpoint_n(flags_n[0]), .arrival_level_a_n(flags_n[1]),
        .arrival_pulse_a_n(flags_n[2]), .arrival_level_b_n(flags_n[3]),
        .arrival_pulse_b_n(flags_n[4]), .overload_notice_one_n(flags_n[5]),
        .overload_notice_two_n(flags_n[6]), .pid_deviation_flag_n(flags_n[7]));
    relay_bank u_relays (.pins_n(flags_n), .coil_on(coil_on));

    initial forever #25 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 2000) begin
            miscompares++;
            report_and_stop;
        end
    end

    task step(input integer n);
        repeat (n) @(negedge ref_clk);
    endtask

    task fa(input [15:0] v, input integer i, input logic e);
        out_freq = v;
        step(3);
        `CHK(flags_n[i], e)
    endtask

    task report_and_stop;
        $display("Compares %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        step(12);
        `CHK(flags_n, 8'hFF)
        `CHK(deviation_level_ff, 16'h0000)
        reset_n = 1;
        step(2);
        `CHK(deviation_level_ff, 16'h012C)
        out_current = 16'h05DC;
        step(2);
        `CHK(flags_n[6:5], 2'b10)
        `CHK(coil_on[5], 1'b1)
        out_current = 16'h03E8;
        step(2);
        `CHK(flags_n[5], 1'b0)
        out_current = 16'h03E7;
        step(2);
        `CHK(flags_n[5], 1'b1)
        out_current = 16'h09C4;
        step(2);
        `CHK(flags_n[6:5], 2'b00)
        out_current = 16'h0000;
        pid_process = 16'h0515;
        step(2);
        `CHK(flags_n[7], 1'b0)
        pid_process = 16'h02BD;
        step(2);
        `CHK(flags_n[7], 1'b1)
        pid_process = 16'h02BB;
        step(2);
        `CHK(flags_n[7], 1'b0)
        deviation_load = 1;
        deviation_level = 16'h0190;
        step(1);
        deviation_load = 0;
        step(2);
        `CHK(deviation_level_ff, 16'h0190)
        `CHK(flags_n[7], 1'b1)
        fa(16'h1323, 0, 1'b1);
        fa(16'h1324, 0, 1'b0);
        fa(16'h1450, 0, 1'b0);
        fa(16'h1451, 0, 1'b1);
        fa(16'h13EC, 0, 1'b0);
        fa(16'h12C0, 0, 1'b0);
        fa(16'h12BF, 0, 1'b1);
        fa(16'h03E8, 2, 1'b1);
        fa(16'h0B53, 1, 1'b1);
        fa(16'h0B54, 1, 1'b0);
        `CHK(flags_n[2], 1'b0)
        fa(16'h0C80, 2, 1'b0);
        fa(16'h0C81, 2, 1'b1);
        fa(16'h0DAC, 1, 1'b0);
        fa(16'h0835, 2, 1'b1);
        fa(16'h0834, 2, 1'b0);
        fa(16'h0708, 1, 1'b0);
        fa(16'h0707, 1, 1'b1);
        `CHK(flags_n[2], 1'b1)
        decel_threshold_b = 16'h1770;
        fa(16'h170B, 3, 1'b1);
        fa(16'h170C, 3, 1'b0);
        `CHK(flags_n[4], 1'b0)
        fa(16'h1839, 4, 1'b1);
        fa(16'h16A7, 3, 1'b1);
        report_and_stop;
    end
endmodule
